// [hw/asd_defs.vh]
// address decoder constants: bases, ranges, reset values
`ifndef ASD_DEFS_VH
`define ASD_DEFS_VH
// short register and bit-offset bases
`define ASD_SFR_BASE      16'hfe00
`define ASD_EXTENDED_REGISTER_SPACE_BASE     16'hf000
`define ASD_BIT_SFR_BASE  16'hff00
`define ASD_BIT_EXTENDED_REGISTER_SPACE_BASE 16'hf100
`define ASD_BIT_RAM_BASE  16'hfd00
`define ASD_GPR_FIRST     8'hf0
`define ASD_BIT_SFR_FIRST 8'h80
// fixed internal block of segment 0
`define ASD_INT_PAGE      12'h00f
`define ASD_RSV_LO        16'hf200
`define ASD_RSV_HI        16'hf5ff
// extended_register_space locations shadowing the core register ranges
`define ASD_EXTENDED_REGISTER_SPACE_CORE0_LO 16'hf000
`define ASD_EXTENDED_REGISTER_SPACE_CORE0_HI 16'hf01e
`define ASD_EXTENDED_REGISTER_SPACE_CORE1_LO 16'hf100
`define ASD_EXTENDED_REGISTER_SPACE_CORE1_HI 16'hf11e
`define ASD_DIR_P0_LO     16'hf100
`define ASD_DIR_P1_HI     16'hf106
// general register windows as a15..a5: ffe0h and f1e0h
`define ASD_GPR_WIN_SFR   11'h7ff
`define ASD_GPR_WIN_EXTENDED_REGISTER_SPACE  11'h78f
// rom window: a23..a15 of the lower 32 kbyte of segment 0 or 1
`define ASD_ROM_SEG0      9'h000
`define ASD_ROM_SEG1      9'h002
// extend command codes
`define ASD_EXT_NONE      2'h0
`define ASD_EXT_REG       2'h1
`define ASD_EXT_SEG       2'h2
`define ASD_EXT_SEGREG    2'h3
// access kinds
`define ASD_ACC_CODE      2'h0
`define ASD_ACC_DATA      2'h1
`define ASD_ACC_REG       2'h2
`define ASD_ACC_BITOFF    2'h3
// reset values
`define ASD_CSP_RST       8'h00
`define ASD_DATA_PAGE_POINTER_RST      10'h000
`define ASD_DPP1_RST      10'h001
`define ASD_DPP2_RST      10'h002
`define ASD_DPP3_RST      10'h003
`define ASD_ASEL_RST      16'h0000
`define ASD_BCFG_RST      16'h0000
// bus config field: range enabled
`define ASD_BCFG_ACT_BIT  10
`endif

// [hw/asd_decoder.v]
// address generation and internal address decoding for the cpu core
`timescale 1ns/1ps
`default_nettype none
`include "asd_defs.vh"
// Contract
// - full 16-bit address reaches an extended register without any prefix.
// - extend-register with count n redirects short accesses of next n instructions.
// - general purpose registers stay reachable by short address, inside or outside.
// - extended locations shadowing core registers are reserved, except port direction.
// - 00f000h to 00ffffh is internal, never an external cycle.
// - f200h to f5ffh is a dummy access: no address, writes lost, reads undefined.
// - enabled rom reserves lower 32 kbyte of segment 0 or 1 internally.
// - physical addresses are 24 bits, a23..a0, 16 mbyte.
// - low 16 bits on first or second port by bus mode, upper on fourth.
// - non-segmented operation confines everything to 64 kbyte of segment 0.
// - segmented operation drives 0, 2, 4 or 8 segment lines.
// - up to five chip selects, each for its own address range.
// - 8-bit code segment pointer gives a23..a16, changed only by segment branches.
// - data space is 1024 pages of 16 kbyte, four page pointers.
// - top two address bits pick a 10-bit page pointer giving a23..a14.
// - five bus configuration and four range select registers.
// - default range bus config is its own register, valid right after reset.
// - extend takes effect at once and covers next 1 to 4 instructions.
// - extend sequence locks interrupts; class b trap ends it and unlocks.
module asd_decoder (
    input  wire        sys_clk,
    input  wire        resetn,
    input  wire        instr_done,
    input  wire [1:0]  ext_cmd,
    input  wire [1:0]  ext_count_m1,
    input  wire [7:0]  ext_seg,
    input  wire        seg_branch,
    input  wire [7:0]  seg_target,
    input  wire        class_b_trap,
    input  wire        dpp_wr,
    input  wire [1:0]  dpp_sel,
    input  wire [9:0]  dpp_wdata,
    input  wire        cfg_wr,
    input  wire [3:0]  cfg_sel,
    input  wire [15:0] cfg_wdata,
    input  wire [15:0] bcfg0_strap,
    input  wire        seg_disable,
    input  wire [1:0]  seg_lines,
    input  wire        rom_enable,
    input  wire        rom_seg1,
    input  wire        mux_mode,
    input  wire        acc_req,
    input  wire [1:0]  acc_kind,
    input  wire [15:0] acc_addr,
    input  wire        acc_write,
    output reg         out_valid_ff,
    output reg  [23:0] phys_addr_ff,
    output reg         internal_ff,
    output reg         dummy_ff,
    output reg         write_discard_ff,
    output reg         extended_register_space_hit_ff,
    output reg         gpr_hit_ff,
    output reg         gpr_mem_misuse_ff,
    output reg         ext_start_ff,
    output reg  [15:0] port0_ad_ff,
    output reg  [15:0] port1_a_ff,
    output reg  [7:0]  port4_a_ff,
    output reg  [4:0]  cs_n_ff,
    output reg  [15:0] bus_cfg_ff,
    output wire        irq_lock,
    output wire [7:0]  csp_out
);
    // segment line mask from the configured line count
    function [7:0] asd_seg_mask;
        input [1:0] code;
        begin
            case (code)
                2'h0:    asd_seg_mask = 8'h00;
                2'h1:    asd_seg_mask = 8'h03;
                2'h2:    asd_seg_mask = 8'h0f;
                default: asd_seg_mask = 8'hff;
            endcase
        end
    endfunction

    // range select: [15:4] base a23..a12, [3:0] size, 4 kbyte << size
    // limitation: a range is aligned to its own size, low base bits are ignored
    function asd_in_range;
        input [23:0] addr;
        input [15:0] sel;
        reg   [11:0] mask;
        begin
            mask = ~((12'h001 << sel[3:0]) - 12'h001);
            asd_in_range = (((addr[23:12] ^ sel[15:4]) & mask) == 12'h000);
        end
    endfunction

    // extend scope state: instructions left and the active redirects
    reg  [2:0]  ext_cnt_ff;
    reg  [2:0]  nxt_ext_cnt;
    reg         ext_reg_ff;
    reg         ext_segon_ff;
    reg  [7:0]  ext_seg_ff;
    reg  [7:0]  csp_ff;
    reg  [9:0]  dpp_ff [0:3];
    reg  [15:0] bcfg_ff [0:4];
    reg  [15:0] asel_ff [1:4];
    integer     i;
    integer     j;

    // extend scope counter; the trap wins over everything but reset
    always @(posedge sys_clk) begin
        if (!resetn) begin
            ext_cnt_ff   <= 3'h0;
            ext_reg_ff   <= 1'b0;
            ext_segon_ff <= 1'b0;
            ext_seg_ff   <= 8'h00;
        end else if (class_b_trap) begin
            ext_cnt_ff   <= 3'h0;
            ext_reg_ff   <= 1'b0;
            ext_segon_ff <= 1'b0;
        end else if (instr_done) begin
            ext_cnt_ff <= nxt_ext_cnt;
            if (ext_cmd != `ASD_EXT_NONE) begin
                ext_reg_ff   <= ext_cmd[0];
                ext_segon_ff <= ext_cmd[1];
                ext_seg_ff   <= ext_seg;
            // the last instruction of the scope drops the redirect with the count
            end else if (ext_cnt_ff == 3'h1) begin
                ext_reg_ff   <= 1'b0;
                ext_segon_ff <= 1'b0;
            end
        end
    end

    // multi-cycle instructions only pulse instr_done once, so they count once
    always @* begin
        if (ext_cmd != `ASD_EXT_NONE)
            nxt_ext_cnt = {1'b0, ext_count_m1} + 3'h1;
        else if (ext_cnt_ff != 3'h0)
            nxt_ext_cnt = ext_cnt_ff - 3'h1;
        else
            nxt_ext_cnt = 3'h0;
    end

    // lock follows the count, so a trap that clears it unlocks at once
    assign irq_lock = (ext_cnt_ff != 3'h0);
    assign csp_out  = csp_ff;

    // code segment pointer and data page pointers
    always @(posedge sys_clk) begin
        if (!resetn) begin
            csp_ff    <= `ASD_CSP_RST;
            dpp_ff[0] <= `ASD_DATA_PAGE_POINTER_RST;
            dpp_ff[1] <= `ASD_DPP1_RST;
            dpp_ff[2] <= `ASD_DPP2_RST;
            dpp_ff[3] <= `ASD_DPP3_RST;
        end else begin
            if (seg_branch)
                csp_ff <= seg_target;
            // an access in the write cycle still sees the old page
            if (dpp_wr)
                dpp_ff[dpp_sel] <= dpp_wdata;
        end
    end

    // bus config 0 loads the startup strap so its timing holds from reset on
    always @(posedge sys_clk) begin
        if (!resetn) begin
            bcfg_ff[0] <= bcfg0_strap;
            for (i = 1; i < 5; i = i + 1) begin
                bcfg_ff[i] <= `ASD_BCFG_RST;
                asel_ff[i] <= `ASD_ASEL_RST;
            end
        end else if (cfg_wr) begin
            // selects above 8 are ignored and leave every register as it was
            if (cfg_sel < 4'h5)
                bcfg_ff[cfg_sel[2:0]] <= cfg_wdata;
            else if (cfg_sel < 4'h9)
                asel_ff[cfg_sel - 4'h4] <= cfg_wdata;
        end
    end

    // short address resolution and physical address formation
    reg  [15:0] short_addr;
    reg  [23:0] phys;
    reg         short_gpr;
    reg         short_extended_register_space;
    always @* begin
        short_gpr  = (acc_addr[7:0] >= `ASD_GPR_FIRST);
        short_extended_register_space = ext_reg_ff && !short_gpr;
        short_addr = 16'h0000;
        if (acc_kind == `ASD_ACC_REG)
            short_addr = (short_extended_register_space ? `ASD_EXTENDED_REGISTER_SPACE_BASE : `ASD_SFR_BASE)
                       + {7'h00, acc_addr[7:0], 1'b0};
        else if (acc_addr[7:0] < `ASD_BIT_SFR_FIRST)
            short_addr = `ASD_BIT_RAM_BASE + {7'h00, acc_addr[7:0], 1'b0};
        else
            short_addr = (short_extended_register_space ? `ASD_BIT_EXTENDED_REGISTER_SPACE_BASE : `ASD_BIT_SFR_BASE)
                       + {7'h00, acc_addr[7:0] - `ASD_BIT_SFR_FIRST, 1'b0};
        // long kinds take their segment from the pointers or the extend segment, short kinds stay in segment 0
        case (acc_kind)
            `ASD_ACC_CODE: phys = {csp_ff, acc_addr};
            `ASD_ACC_DATA: begin
                if (ext_segon_ff)
                    phys = {ext_seg_ff, acc_addr};
                else
                    phys = {dpp_ff[acc_addr[15:14]], acc_addr[13:0]};
            end
            default:       phys = {8'h00, short_addr};
        endcase
        // non-segmented mode drops the segment so nothing leaves segment 0
        if (seg_disable)
            phys = {8'h00, phys[15:0]};
    end

    // internal, dummy and reserved decoding; full 16-bit addresses decode directly
    wire in_int   = (phys[23:12] == `ASD_INT_PAGE);
    wire in_rsv   = in_int && (phys[15:0] >= `ASD_RSV_LO) &&
                    (phys[15:0] <= `ASD_RSV_HI);
    wire in_core  = in_int && (((phys[15:0] >= `ASD_EXTENDED_REGISTER_SPACE_CORE0_LO) &&
                    (phys[15:0] <= `ASD_EXTENDED_REGISTER_SPACE_CORE0_HI)) ||
                    ((phys[15:0] >= `ASD_EXTENDED_REGISTER_SPACE_CORE1_LO) &&
                    (phys[15:0] <= `ASD_EXTENDED_REGISTER_SPACE_CORE1_HI)));
    wire in_dir   = (phys[15:0] >= `ASD_DIR_P0_LO) && (phys[15:0] <= `ASD_DIR_P1_HI);
    wire extended_register_space_rsv = in_core && !in_dir;
    // whole 32 kbyte window is internal; a smaller rom is mirrored across it
    wire in_rom   = rom_enable && (phys[23:15] ==
                    (rom_seg1 ? `ASD_ROM_SEG1 : `ASD_ROM_SEG0));
    wire is_int   = in_int || in_rom;
    // extended registers decode from the full address, no prefix needed
    wire is_extended_register_space  = in_int && (phys[15:9] == `ASD_EXTENDED_REGISTER_SPACE_BASE >> 9);
    wire long_acc = (acc_kind == `ASD_ACC_CODE) || (acc_kind == `ASD_ACC_DATA);
    // general register windows reached by a long address are flagged as misuse
    wire gpr_win_sfr  = (phys[15:5] == `ASD_GPR_WIN_SFR);
    wire gpr_win_extended_register_space = (phys[15:5] == `ASD_GPR_WIN_EXTENDED_REGISTER_SPACE);
    wire gpr_mem  = long_acc && in_int && (gpr_win_sfr || gpr_win_extended_register_space);

    // range selection: lowest matching enabled range wins, none means range 0
    wire [4:1] rng_hit;
    genvar g;
    generate
        for (g = 1; g < 5; g = g + 1) begin : g_rng
            assign rng_hit[g] = bcfg_ff[g][`ASD_BCFG_ACT_BIT] &&
                                asd_in_range(phys, asel_ff[g]);
        end
    endgenerate

    // descending loop so the lowest matching index is assigned last and wins
    reg  [2:0] rng_sel;
    always @* begin
        rng_sel = 3'h0;
        for (j = 4; j > 0; j = j - 1)
            if (rng_hit[j])
                rng_sel = j[2:0];
    end

    // result registers: one cycle after the request
    wire go_ext = acc_req && !is_int;
    always @(posedge sys_clk) begin
        if (!resetn) begin
            out_valid_ff      <= 1'b0;
            phys_addr_ff      <= 24'h000000;
            internal_ff       <= 1'b0;
            dummy_ff          <= 1'b0;
            write_discard_ff  <= 1'b0;
            extended_register_space_hit_ff       <= 1'b0;
            gpr_hit_ff        <= 1'b0;
            gpr_mem_misuse_ff <= 1'b0;
            ext_start_ff      <= 1'b0;
            port0_ad_ff       <= 16'h0000;
            port1_a_ff        <= 16'h0000;
            port4_a_ff        <= 8'h00;
            cs_n_ff           <= 5'h1f;
            bus_cfg_ff        <= 16'h0000;
        end else begin
            // strobes are rebuilt every cycle so they stand for exactly one cycle
            out_valid_ff      <= acc_req;
            ext_start_ff      <= go_ext;
            write_discard_ff  <= acc_req && acc_write && (in_rsv || extended_register_space_rsv);
            cs_n_ff           <= 5'h1f;
            if (acc_req) begin
                phys_addr_ff      <= phys;
                internal_ff       <= is_int;
                dummy_ff          <= in_rsv || extended_register_space_rsv;
                extended_register_space_hit_ff       <= is_extended_register_space;
                gpr_hit_ff        <= !long_acc && short_gpr;
                gpr_mem_misuse_ff <= gpr_mem;
            end
            // address pins only move for external cycles; internal ones leave them
            if (go_ext) begin
                if (mux_mode)
                    port0_ad_ff <= phys[15:0];
                else
                    port1_a_ff  <= phys[15:0];
                port4_a_ff <= seg_disable ? 8'h00 :
                              (phys[23:16] & asd_seg_mask(seg_lines));
                cs_n_ff[rng_sel] <= 1'b0;
                bus_cfg_ff       <= bcfg_ff[rng_sel];
            end
        end
    end
endmodule
`default_nettype wire

// [verif/asd_checker_properties.sv]
// concurrent checks on the address decoder ports
`timescale 1ns/1ps
`default_nettype none
module asd_checker (
    input wire logic        sys_clk,
    input wire logic        resetn,
    input wire logic        acc_req,
    input wire logic        acc_write,
    input wire logic        instr_done,
    input wire logic [1:0]  ext_cmd,
    input wire logic        class_b_trap,
    input wire logic        seg_branch,
    input wire logic        seg_disable,
    input wire logic        mux_mode,
    input wire logic        out_valid_ff,
    input wire logic [23:0] phys_addr_ff,
    input wire logic        internal_ff,
    input wire logic        dummy_ff,
    input wire logic        write_discard_ff,
    input wire logic        ext_start_ff,
    input wire logic [15:0] port1_a_ff,
    input wire logic [4:0]  cs_n_ff,
    input wire logic        irq_lock,
    input wire logic [7:0]  csp_out
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    // answer comes exactly one cycle after the request
    a_valid_one_cycle: assert property (acc_req |=> out_valid_ff) else $error("no answer");
    a_int_no_ext: assert property (out_valid_ff && phys_addr_ff[23:12] == 12'h00f
        |-> internal_ff && !ext_start_ff) else $error("internal block went out");
    a_ext_not_int: assert property (ext_start_ff |-> out_valid_ff && !internal_ff)
        else $error("external cycle on internal address");
    a_rsv_dummy: assert property (out_valid_ff && phys_addr_ff >= 24'h00f200
        && phys_addr_ff <= 24'h00f5ff |-> dummy_ff) else $error("reserved not dummy");
    a_discard_write: assert property (write_discard_ff |-> dummy_ff && $past(acc_write))
        else $error("discard without dummy write");
    a_nonseg_seg0: assert property (out_valid_ff && $past(seg_disable)
        |-> phys_addr_ff[23:16] == 8'h00) else $error("left segment 0");
    a_port_demux: assert property (ext_start_ff && !$past(mux_mode)
        |-> port1_a_ff == phys_addr_ff[15:0]) else $error("demux port wrong");
    a_cs_one_hot: assert property (ext_start_ff |-> $onehot(~cs_n_ff))
        else $error("select not one-hot");
    a_cs_idle: assert property (!ext_start_ff |-> cs_n_ff == 5'h1f)
        else $error("select without cycle");
    a_csp_branch_only: assert property (!seg_branch |=> $stable(csp_out))
        else $error("code segment moved");
    a_lock_set: assert property (instr_done && ext_cmd != 2'h0 && !class_b_trap
        |=> irq_lock) else $error("no lock");
    a_trap_unlock: assert property (class_b_trap |=> !irq_lock)
        else $error("trap left lock");
    c_ext: cover property (ext_start_ff);
    c_dummy: cover property (out_valid_ff && dummy_ff);
    c_scope_end: cover property (irq_lock ##1 !irq_lock);
endmodule
bind asd_decoder asd_checker asd_checker_i (.*);
`default_nettype wire

// [verif/asd_ext_mem.sv]
// far side memory: counts external cycles and keeps the last address seen
`timescale 1ns/1ps
`default_nettype none
module asd_ext_mem (
    input wire logic        sys_clk,
    input wire logic        resetn,
    input wire logic        ext_start,
    input wire logic [4:0]  cs_n,
    input wire logic [15:0] addr_lo,
    input wire logic [7:0]  addr_hi,
    output var logic [7:0]  cycles,
    output var logic [23:0] last_addr
);
    // only a selected cycle counts, so a stray strobe without select is missed on purpose
    always @(posedge sys_clk) begin
        if (!resetn) begin
            cycles <= 8'h00;
            last_addr <= 24'h000000;
        end else if (ext_start && cs_n != 5'h1f) begin
            cycles <= cycles + 8'h01;
            last_addr <= {addr_hi, addr_lo};
        end
    end
endmodule
`default_nettype wire

// [verif/address_space_decoder_tb.sv]
// self-checking bench for the address decoder
`timescale 1ns/1ps
`default_nettype none
`include "asd_defs.vh"
module address_space_decoder_tb;
    logic        sys_clk, resetn, instr_done, seg_branch, class_b_trap, dpp_wr, cfg_wr;
    logic        seg_disable, rom_enable, rom_seg1, mux_mode, acc_req, acc_write;
    logic [1:0]  ext_cmd, ext_count_m1, dpp_sel, seg_lines, acc_kind;
    logic [7:0]  ext_seg, seg_target, port4_a_ff, csp_out, cycles;
    logic [9:0]  dpp_wdata;
    logic [3:0]  cfg_sel;
    logic [15:0] cfg_wdata, bcfg0_strap, acc_addr, port0_ad_ff, port1_a_ff, bus_cfg_ff;
    logic [23:0] phys_addr_ff, last_addr;
    logic        out_valid_ff, internal_ff, dummy_ff, write_discard_ff, extended_register_space_hit_ff;
    logic        gpr_hit_ff, gpr_mem_misuse_ff, ext_start_ff, irq_lock;
    logic [4:0]  cs_n_ff;
    int          err_count, compares;
    asd_decoder asd_decoder_i (.*);
    asd_ext_mem asd_ext_mem_i (.sys_clk(sys_clk), .resetn(resetn), .ext_start(ext_start_ff),
        .cs_n(cs_n_ff), .addr_lo(port1_a_ff), .addr_hi(port4_a_ff), .cycles(cycles),
        .last_addr(last_addr));
    always #25 sys_clk = ~sys_clk;
    task automatic final_report;
        if (err_count == 0 && compares > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // inputs always move 5 ns after the rising edge
    task automatic tick;
        @(posedge sys_clk);
        #5;
    endtask
    // each request starts one edge after the last was lowered, so no strobe is set twice
    task automatic acc(input logic [1:0] k, input logic [15:0] a, input logic w);
        tick;
        acc_req = 1; acc_kind = k; acc_addr = a; acc_write = w;
        tick;
        acc_req = 0; acc_write = 0;
    endtask
    task automatic instr(input logic [1:0] c, input logic [1:0] m);
        tick;
        instr_done = 1; ext_cmd = c; ext_count_m1 = m;
        tick;
        instr_done = 0; ext_cmd = `ASD_EXT_NONE;
    endtask
    task automatic branch(input logic [7:0] s);
        tick;
        seg_branch = 1; seg_target = s;
        tick;
        seg_branch = 0;
    endtask
    task automatic cfg(input logic [3:0] s, input logic [15:0] d);
        tick;
        cfg_wr = 1; cfg_sel = s; cfg_wdata = d;
        tick;
        cfg_wr = 0;
    endtask
    task automatic t_code;
        branch(8'h12);
        acc(`ASD_ACC_CODE, 16'h1234, 0);
        chk(phys_addr_ff, 24'h121234);
        chk({port4_a_ff, port1_a_ff}, 24'h121234);
        chk({cs_n_ff, bus_cfg_ff}, {5'h1e, 16'h0240});
        mux_mode = 1;
        acc(`ASD_ACC_CODE, 16'h5678, 0);
        chk(port0_ad_ff, 16'h5678);
        mux_mode = 0; seg_lines = 2'h1;
        acc(`ASD_ACC_CODE, 16'h0002, 0);
        chk(port4_a_ff, 8'h02);
        seg_lines = 2'h3;
    endtask
    task automatic t_data;
        dpp_wr = 1; dpp_sel = 2'h2; dpp_wdata = 10'h3ff;
        tick;
        dpp_wr = 0;
        acc(`ASD_ACC_DATA, 16'h8123, 0);
        chk(phys_addr_ff, 24'hffc123);
        acc(`ASD_ACC_DATA, 16'hf300, 1);
        chk({internal_ff, dummy_ff, write_discard_ff, ext_start_ff}, 4'b1110);
        acc(`ASD_ACC_DATA, 16'hf600, 0);
        chk({internal_ff, dummy_ff, ext_start_ff, gpr_mem_misuse_ff}, 4'b1000);
        acc(`ASD_ACC_DATA, 16'hf020, 0);
        chk({extended_register_space_hit_ff, dummy_ff}, 2'b10);
        acc(`ASD_ACC_DATA, 16'hf010, 0);
        chk(dummy_ff, 1'b1);
        acc(`ASD_ACC_DATA, 16'hf102, 0);
        chk(dummy_ff, 1'b0);
        acc(`ASD_ACC_DATA, 16'hffe4, 0);
        chk(gpr_mem_misuse_ff, 1'b1);
        acc(`ASD_ACC_DATA, 16'hf1e2, 0);
        chk({gpr_mem_misuse_ff, dummy_ff}, 2'b10);
    endtask
    task automatic t_extend_register_instruction;
        instr(`ASD_EXT_REG, 2'h3);
        chk(irq_lock, 1'b1);
        acc(`ASD_ACC_REG, 16'h0010, 0);
        chk(phys_addr_ff, 24'h00f020);
        acc(`ASD_ACC_BITOFF, 16'h0085, 0);
        chk(phys_addr_ff, 24'h00f10a);
        acc(`ASD_ACC_REG, 16'h00f2, 0);
        chk({gpr_hit_ff, phys_addr_ff}, {1'b1, 24'h00ffe4});
        repeat (3) instr(`ASD_EXT_NONE, 2'h0);
        chk(irq_lock, 1'b1);
        instr(`ASD_EXT_NONE, 2'h0);
        chk(irq_lock, 1'b0);
        acc(`ASD_ACC_REG, 16'h0010, 0);
        chk(phys_addr_ff, 24'h00fe20);
        ext_seg = 8'h34;
        instr(`ASD_EXT_SEGREG, 2'h1);
        acc(`ASD_ACC_DATA, 16'h0100, 0);
        chk(phys_addr_ff, 24'h340100);
        class_b_trap = 1;
        tick;
        class_b_trap = 0;
        chk(irq_lock, 1'b0);
        acc(`ASD_ACC_REG, 16'h0010, 0);
        chk(phys_addr_ff, 24'h00fe20);
    endtask
    task automatic t_cfg;
        cfg(4'h1, 16'h0401);
        cfg(4'h5, 16'h2504);
        cfg(4'h9, 16'hffff);
        branch(8'h25);
        seg_lines = 2'h2;
        acc(`ASD_ACC_CODE, 16'h1000, 0);
        chk({cs_n_ff, bus_cfg_ff}, {5'h1d, 16'h0401});
        chk(port4_a_ff, 8'h05);
        seg_lines = 2'h0;
        acc(`ASD_ACC_CODE, 16'hfff0, 0);
        chk({port4_a_ff, cs_n_ff}, {8'h00, 5'h1d});
        seg_lines = 2'h3;
    endtask
    task automatic t_rom;
        rom_enable = 1; rom_seg1 = 1;
        branch(8'h01);
        acc(`ASD_ACC_CODE, 16'h7ffe, 0);
        chk({internal_ff, ext_start_ff}, 2'b10);
        acc(`ASD_ACC_CODE, 16'h8000, 0);
        chk({internal_ff, ext_start_ff}, 2'b01);
        rom_enable = 0; seg_disable = 1;
        acc(`ASD_ACC_CODE, 16'h1234, 0);
        chk(phys_addr_ff, 24'h001234);
        tick;
        chk({cycles, last_addr}, {8'h09, 24'h001234});
    endtask
    initial begin
        sys_clk = 0; resetn = 0; instr_done = 0; seg_branch = 0; class_b_trap = 0;
        dpp_wr = 0; cfg_wr = 0; seg_disable = 0; rom_enable = 0; rom_seg1 = 0;
        mux_mode = 0; acc_req = 0; acc_write = 0; ext_cmd = 0; ext_count_m1 = 0;
        dpp_sel = 0; seg_lines = 2'h3; acc_kind = 0; ext_seg = 8'h00; seg_target = 8'h00;
        dpp_wdata = 10'h000; cfg_sel = 4'h0; cfg_wdata = 16'h0000; bcfg0_strap = 16'h0240;
        acc_addr = 16'h0000; err_count = 0; compares = 0;
        repeat (3) tick;
        resetn = 1;
        t_code;
        t_data;
        t_extend_register_instruction;
        t_cfg;
        t_rom;
        final_report;
    end
    // hang guard: far beyond the under 100 cycles the run needs
    initial begin
        #1000000;
        err_count++;
        final_report;
    end
endmodule
`default_nettype wire
